// file: include/frs_params.svh
// constants for the floppy rate and status register slice
`ifndef FRS_PARAMS_SVH
`define FRS_PARAMS_SVH
// -------------------------------------------------------------
// register indices (byte address is four times the index)
// -------------------------------------------------------------
`define FRS_IDX_DOR 6'h02
`define FRS_IDX_DATA 6'h05
`define FRS_IDX_DIR_CCR 6'h07
`define FRS_IDX_MODE 6'h08
`define FRS_IDX_CTRL 6'h09
// -------------------------------------------------------------
// field positions
// -------------------------------------------------------------
`define FRS_DOR_DMA_BIT 3
`define FRS_CCR_NOPREC_BIT 2
`define FRS_CTRL_SRST_BIT 0
`define FRS_CTRL_FORCE_DC_BIT 1
`define FRS_ST1_EN_BIT 7
`define FRS_ST1_DE_BIT 5
`define FRS_ST1_OR_BIT 4
`define FRS_ST1_ND_BIT 2
`define FRS_ST1_NW_BIT 1
`define FRS_ST1_MA_BIT 0
// -------------------------------------------------------------
// reset values
// -------------------------------------------------------------
`define FRS_RATE_RST 2'h2
`define FRS_DOR_RST 8'h00
`define FRS_MODE_RST 2'h0
// -------------------------------------------------------------
// counts
// -------------------------------------------------------------
`define FRS_RECAL_STEPS 7'h50
`define FRS_ID_INDEX_LIMIT 2'h2
`endif

// file: include/frs_pkg.sv
// types for the floppy rate and status register slice
package frs_pkg;
  typedef enum logic [1:0] {
    FRS_MODE_AT = 2'b00,
    FRS_MODE_B = 2'b01,
    FRS_MODE_C = 2'b10
  } frs_mode_t;
  typedef enum logic [1:0] {
    FRS_ST_IDLE = 2'b00,
    FRS_ST_EXEC = 2'b01,
    FRS_ST_RESULT = 2'b10
  } frs_state_t;
endpackage

// file: design/frs_regs.sv
// floppy rate select, input/config registers and result status bytes
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ps
`include "frs_params.svh"
module frs_regs
  import frs_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rstn,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [31:0] o_prdata,
  // drive cable pins, asynchronous
  input wire logic i_disk_change_pin,
  input wire logic i_track_zero_pin,
  input wire logic i_index_pin,
  input wire logic i_write_protect_pin,
  // controller core, same clock
  input wire logic i_cmd_start,
  input wire logic i_cmd_done,
  input wire logic [1:0] i_termination_code,
  input wire logic i_head,
  input wire logic [1:0] i_drive_select_bits,
  input wire logic i_positioning_done,
  input wire logic i_recal_active,
  input wire logic i_step_pulse,
  input wire logic i_seek_past_zero,
  input wire logic i_past_last_sector,
  input wire logic i_crc_fault,
  input wire logic i_late_service,
  input wire logic i_sector_not_found,
  input wire logic i_write_active,
  input wire logic i_id_search,
  input wire logic i_id_found,
  input wire logic i_no_data_mark,
  // controls
  output logic [1:0] o_rate_sel,
  output logic o_noprec,
  output logic o_dma_enable_flag,
  output logic o_result_phase,
  output logic o_core_reset
);
  // -----------------------------------------------------------
  // pin synchronisers: {write protect, index, track zero, change}
  // -----------------------------------------------------------
  logic [3:0] pin_s1_r;
  logic [3:0] pin_s2_r;
  logic idx_prev_r;

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      pin_s1_r <= 4'h0;
      pin_s2_r <= 4'h0;
      idx_prev_r <= 1'b0;
    end
    else
    begin
      pin_s1_r <= {i_write_protect_pin, i_index_pin, i_track_zero_pin, i_disk_change_pin};
      pin_s2_r <= pin_s1_r;
      idx_prev_r <= pin_s2_r[2];
    end
  end

  // -----------------------------------------------------------
  // apb slave and register file
  // -----------------------------------------------------------
  function automatic logic [5:0] reg_idx(input logic [7:0] addr);
    reg_idx = addr[7:2];
  endfunction

  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic [1:0] rate_r, rate_nxt;
  logic noprec_r, noprec_nxt;
  logic [7:0] dor_r, dor_nxt;
  frs_mode_t mode_r, mode_nxt;
  logic force_dc_r, force_dc_nxt;
  logic core_rst_r, core_rst_nxt;
  logic res_pop;
  logic acc_first;
  logic acc_done;
  logic mapped;
  logic disk_change_flag;
  logic [7:0] dir_val;
  logic [7:0] st0_val;
  logic [5:0] idx;

  frs_state_t state_r, state_nxt;
  logic [1:0] term_r, term_nxt;
  logic se_r, se_nxt;
  logic ec_r, ec_nxt;
  logic [7:0] st1_r, st1_nxt;
  logic res_idx_r, res_idx_nxt;

  assign acc_first = i_psel & i_penable & !pready_r;
  assign acc_done = i_psel & i_penable & pready_r;
  assign idx = reg_idx(i_paddr);
  assign disk_change_flag = ~pin_s2_r[0] | force_dc_r;
  assign st0_val = {term_r, se_r, ec_r, 1'b0, i_head, i_drive_select_bits};

  always_comb
  begin
    dir_val = {disk_change_flag, 7'h00};
    unique case (mode_r)
      FRS_MODE_AT: dir_val = {disk_change_flag, 7'h00};
      FRS_MODE_B: dir_val = {disk_change_flag, 4'hF, rate_r, rate_r[1] ^ rate_r[0]};
      FRS_MODE_C: dir_val = {disk_change_flag, 3'h0, dor_r[`FRS_DOR_DMA_BIT], noprec_r, rate_r};
    endcase
  end

  always_comb
  begin
    pready_nxt = acc_first;
    pslverr_nxt = 1'b0;
    prdata_nxt = prdata_r;
    rate_nxt = rate_r;
    noprec_nxt = noprec_r;
    dor_nxt = dor_r;
    mode_nxt = mode_r;
    force_dc_nxt = force_dc_r;
    core_rst_nxt = 1'b0;
    res_pop = 1'b0;
    mapped = (i_paddr[1:0] == 2'h0) &&
      (idx == `FRS_IDX_DOR || idx == `FRS_IDX_DATA || idx == `FRS_IDX_DIR_CCR ||
       idx == `FRS_IDX_MODE || idx == `FRS_IDX_CTRL);
    if (acc_first)
    begin
      pslverr_nxt = !mapped || (i_pwrite && idx == `FRS_IDX_DATA);
      prdata_nxt = 32'h0000_0000;
      if (!i_pwrite && mapped)
      begin
        unique case (idx)
          `FRS_IDX_DOR: prdata_nxt[7:0] = dor_r;
          `FRS_IDX_DATA: prdata_nxt[7:0] = (state_r != FRS_ST_RESULT) ? 8'h00 :
                                           (res_idx_r ? st1_r : st0_val);
          `FRS_IDX_DIR_CCR: prdata_nxt[7:0] = dir_val;
          `FRS_IDX_MODE: prdata_nxt[1:0] = mode_r;
          default: prdata_nxt[`FRS_CTRL_FORCE_DC_BIT] = force_dc_r;
        endcase
      end
    end
    if (acc_done && mapped)
    begin
      if (i_pwrite)
      begin
        unique case (idx)
          `FRS_IDX_DOR: dor_nxt = i_pwdata[7:0];
          `FRS_IDX_DATA: dor_nxt = dor_r;
          `FRS_IDX_DIR_CCR:
          begin
            rate_nxt = i_pwdata[1:0];
            if (mode_r == FRS_MODE_C)
              noprec_nxt = i_pwdata[`FRS_CCR_NOPREC_BIT];
          end
          `FRS_IDX_MODE:
          begin
            if (i_pwdata[1:0] != 2'h3)
              mode_nxt = frs_mode_t'(i_pwdata[1:0]);
          end
          default:
          begin
            force_dc_nxt = i_pwdata[`FRS_CTRL_FORCE_DC_BIT];
            core_rst_nxt = i_pwdata[`FRS_CTRL_SRST_BIT];
          end
        endcase
      end
      else if (idx == `FRS_IDX_DATA && state_r == FRS_ST_RESULT)
        res_pop = 1'b1;
    end
  end

  // software reset leaves rate and noprec alone
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      rate_r <= `FRS_RATE_RST;
      noprec_r <= 1'b0;
      dor_r <= `FRS_DOR_RST;
      mode_r <= frs_mode_t'(`FRS_MODE_RST);
      force_dc_r <= 1'b0;
      core_rst_r <= 1'b0;
    end
    else
    begin
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
      prdata_r <= prdata_nxt;
      rate_r <= rate_nxt;
      noprec_r <= noprec_nxt;
      dor_r <= dor_nxt;
      mode_r <= mode_nxt;
      force_dc_r <= force_dc_nxt;
      core_rst_r <= core_rst_nxt;
    end
  end

  // -----------------------------------------------------------
  // result status collection
  // -----------------------------------------------------------
  logic [6:0] step_cnt_r, step_cnt_nxt;
  logic [1:0] idx_cnt_r, idx_cnt_nxt;
  logic idx_edge;
  logic recal_fail;
  logic ma_fail;
  logic clr;
  logic [7:0] ev1;

  assign idx_edge = pin_s2_r[2] & ~idx_prev_r;

  always_comb
  begin
    clr = i_cmd_start | core_rst_r;
    step_cnt_nxt = step_cnt_r;
    if (!i_recal_active)
      step_cnt_nxt = 7'h00;
    else if (i_step_pulse && step_cnt_r != `FRS_RECAL_STEPS)
      step_cnt_nxt = step_cnt_r + 7'h01;
    recal_fail = i_recal_active && i_step_pulse && !pin_s2_r[1] &&
      (step_cnt_r == `FRS_RECAL_STEPS - 7'h01);
    idx_cnt_nxt = idx_cnt_r;
    if (!i_id_search || i_id_found)
      idx_cnt_nxt = 2'h0;
    else if (idx_edge && idx_cnt_r != `FRS_ID_INDEX_LIMIT)
      idx_cnt_nxt = idx_cnt_r + 2'h1;
    ma_fail = i_id_search && !i_id_found && idx_edge &&
      (idx_cnt_r == `FRS_ID_INDEX_LIMIT - 2'h1);
    ev1 = 8'h00;
    ev1[`FRS_ST1_EN_BIT] = i_past_last_sector;
    ev1[`FRS_ST1_DE_BIT] = i_crc_fault;
    ev1[`FRS_ST1_OR_BIT] = i_late_service;
    ev1[`FRS_ST1_ND_BIT] = i_sector_not_found;
    ev1[`FRS_ST1_NW_BIT] = i_write_active & pin_s2_r[3];
    ev1[`FRS_ST1_MA_BIT] = ma_fail | i_no_data_mark;
    // a new event wins over the clear in the same cycle
    st1_nxt = (clr ? 8'h00 : st1_r) | ev1;
    se_nxt = (clr ? 1'b0 : se_r) | i_positioning_done;
    ec_nxt = (clr ? 1'b0 : ec_r) | recal_fail | i_seek_past_zero;
    state_nxt = state_r;
    term_nxt = term_r;
    res_idx_nxt = res_idx_r;
    unique case (state_r)
      FRS_ST_IDLE: state_nxt = state_r;
      FRS_ST_EXEC:
      begin
        if (i_cmd_done)
        begin
          state_nxt = FRS_ST_RESULT;
          term_nxt = i_termination_code;
          res_idx_nxt = 1'b0;
        end
      end
      FRS_ST_RESULT:
      begin
        if (res_pop)
        begin
          res_idx_nxt = 1'b1;
          if (res_idx_r)
          begin
            state_nxt = FRS_ST_IDLE;
            res_idx_nxt = 1'b0;
          end
        end
      end
      default: state_nxt = FRS_ST_IDLE;
    endcase
    if (i_cmd_start)
    begin
      state_nxt = FRS_ST_EXEC;
      res_idx_nxt = 1'b0;
    end
    if (core_rst_r)
    begin
      state_nxt = FRS_ST_IDLE;
      res_idx_nxt = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rstn)
    begin
      state_r <= FRS_ST_IDLE;
      term_r <= 2'h0;
      se_r <= 1'b0;
      ec_r <= 1'b0;
      st1_r <= 8'h00;
      res_idx_r <= 1'b0;
      step_cnt_r <= 7'h00;
      idx_cnt_r <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      term_r <= term_nxt;
      se_r <= se_nxt;
      ec_r <= ec_nxt;
      st1_r <= st1_nxt;
      res_idx_r <= res_idx_nxt;
      step_cnt_r <= step_cnt_nxt;
      idx_cnt_r <= idx_cnt_nxt;
    end
  end

  // -----------------------------------------------------------
  // outputs
  // -----------------------------------------------------------
  assign o_pready = pready_r;
  assign o_pslverr = pslverr_r;
  assign o_prdata = prdata_r;
  assign o_rate_sel = rate_r;
  assign o_noprec = noprec_r;
  assign o_dma_enable_flag = dor_r[`FRS_DOR_DMA_BIT];
  assign o_result_phase = state_r[1];
  assign o_core_reset = core_rst_r;

  // -----------------------------------------------------------
  // assertions
  // -----------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rstn);

  sequence s_dir_read;
    acc_done && !i_pwrite && idx == `FRS_IDX_DIR_CCR && i_paddr[1:0] == 2'h0;
  endsequence
  sequence s_ccr_write;
    acc_done && i_pwrite && idx == `FRS_IDX_DIR_CCR && i_paddr[1:0] == 2'h0;
  endsequence
  sequence s_eightieth_step;
    i_recal_active && i_step_pulse && step_cnt_r == 7'h4F && !pin_s2_r[1];
  endsequence
  sequence s_second_index;
    i_id_search && !i_id_found && idx_edge && idx_cnt_r == 2'h1;
  endsequence

  hw_rate_reset_a: assert property (
    @(posedge i_ref_clk) disable iff (1'b0)
    !i_rstn |=> rate_r == 2'h2 && !noprec_r)
    else $error("rate not 250K after hardware reset");
  soft_rate_keep_a: assert property (
    core_rst_r |=> $stable(rate_r) && $stable(noprec_r))
    else $error("software reset changed rate or noprec");
  dirb_ones_a: assert property (
    s_dir_read and (mode_r == FRS_MODE_B) |->
    o_prdata[6:3] == 4'hF && o_prdata[2:1] == rate_r)
    else $error("mode B input bits wrong");
  disk_change_flag_a: assert property (
    s_dir_read |-> o_prdata[7] == $past(disk_change_flag))
    else $error("disk change bit wrong");
  modec_mirror_a: assert property (
    s_dir_read and (mode_r == FRS_MODE_C) |->
    o_prdata[6:0] == {3'h0, dor_r[3], noprec_r, rate_r})
    else $error("mode C input bits wrong");
  ccr_write_a: assert property (
    s_ccr_write |=> rate_r == $past(i_pwdata[1:0]) ##1 o_rate_sel == rate_r)
    else $error("config write did not set rate");
  ccr_reserved_a: assert property (
    s_ccr_write and (mode_r != FRS_MODE_C) |=> $stable(noprec_r))
    else $error("reserved config bit stored");
  term_code_a: assert property (
    res_pop && !res_idx_r |-> o_prdata[7:6] == term_r && o_prdata[3] == 1'b0)
    else $error("status0 code or bit3 wrong");
  result_order_a: assert property (
    res_pop && !res_idx_r && !core_rst_r && !i_cmd_start |=>
    res_idx_r && o_result_phase)
    else $error("result phase ordering wrong");
  home_fault_a: assert property (
    s_eightieth_step |=> ec_r)
    else $error("home fault not flagged after 80 steps");
  id_mark_a: assert property (
    s_second_index |=> st1_r[0])
    else $error("missing id mark not flagged");
  st1_events_a: assert property (
    ev1 != 8'h00 |=> (st1_r & $past(ev1)) == $past(ev1) && st1_r[6] == 1'b0 &&
    st1_r[3] == 1'b0)
    else $error("status1 event lost");
  seek_end_a: assert property (
    i_positioning_done |=> se_r)
    else $error("positioning done not flagged");
  apb_answer_a: assert property (
    acc_first |=> o_pready ##1 !o_pready)
    else $error("apb answer timing wrong");
endmodule

// file: tb/frs_host.sv
// apb master model standing in for the host processor
`timescale 1ns/1ps
module frs_host (
  // bus clock
  input wire logic i_ref_clk,
  // apb master side
  output logic o_psel,
  output logic o_penable,
  output logic o_pwrite,
  output logic [7:0] o_paddr,
  output logic [31:0] o_pwdata,
  input wire logic i_pready
);
  initial
  begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 8'h00;
    o_pwdata = 32'h0;
  end
  // one transfer: setup, then access held until pready is seen high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    o_psel <= 1'b1;
    o_penable <= 1'b0;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_ref_clk);
    o_penable <= 1'b1;
    do
      @(posedge i_ref_clk);
    while (i_pready !== 1'b1);
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    // released address and data lines must not keep the last value
    o_paddr <= ~a;
    o_pwdata <= ~d;
  endtask
endmodule

// file: tb/tb.sv
// self-checking bench for the floppy rate and status register slice
`timescale 1ns/1ps
`include "frs_params.svh"
module tb;
  logic clk = 1'b0, rstn = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, v;
  logic dchg = 1'b0, track_zero_pin = 1'b0, wp = 1'b0, start = 1'b0, cdone = 1'b0, head = 1'b0;
  logic pdone = 1'b0, recal = 1'b0, step = 1'b0, spz = 1'b0, pls = 1'b0, crc = 1'b0;
  logic late = 1'b0, snf = 1'b0, wact = 1'b0, ndm = 1'b0, ipin = 1'b0, srch = 1'b0;
  logic [1:0] term = 2'h0, drv = 2'h0, rate;
  logic noprec, dma, rphase, crst, found = 1'b0;
  logic [33:0] exp_q[$];
  logic [33:0] e;
  int fails = 0, checked = 0, cycles = 0, k, seed;
  initial
  begin
    forever #4 clk = ~clk;
  end
  frs_host host_u (.i_ref_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
    .o_paddr(paddr), .o_pwdata(pwdata), .i_pready(pready));
  frs_regs dut_u (.i_ref_clk(clk), .i_rstn(rstn), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_prdata(prdata), .i_disk_change_pin(dchg),
    .i_track_zero_pin(track_zero_pin), .i_index_pin(ipin), .i_write_protect_pin(wp),
    .i_cmd_start(start), .i_cmd_done(cdone), .i_termination_code(term), .i_head(head),
    .i_drive_select_bits(drv), .i_positioning_done(pdone), .i_recal_active(recal),
    .i_step_pulse(step), .i_seek_past_zero(spz), .i_past_last_sector(pls),
    .i_crc_fault(crc), .i_late_service(late), .i_sector_not_found(snf),
    .i_write_active(wact), .i_id_search(srch), .i_id_found(found), .i_no_data_mark(ndm),
    .o_rate_sel(rate), .o_noprec(noprec), .o_dma_enable_flag(dma),
    .o_result_phase(rphase), .o_core_reset(crst));
  task automatic stop_test;
    if (fails == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] want);
    checked++;
    if (seen !== want)
    begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask
  // note the expected answer, then run the transfer
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
    input logic [33:0] x);
    exp_q.push_back(x);
    host_u.xfer(w, a, {24'h0, d});
  endtask
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    acc(1'b1, {idx, 2'b00}, d, 34'h0);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [7:0] want);
    acc(1'b0, {idx, 2'b00}, 8'h00, {2'b10, 24'h0, want});
  endtask
  task automatic hard_rst;
    @(posedge clk);
    rstn <= 1'b0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
  endtask
  function automatic logic [7:0] mb(input logic b7, input logic [1:0] r);
    return {b7, 4'hF, r, ^r};
  endfunction
  // result watcher: oldest note against each completed transfer
  always @(posedge clk)
  begin
    cycles++;
    if (psel && penable && pready && exp_q.size() > 0)
    begin
      e = exp_q.pop_front();
      chk({pslverr, e[33] ? prdata : 32'h0}, e[32:0]);
    end
    if (cycles == 6000)
    begin
      fails++;
      stop_test;
    end
  end
  initial
  begin
    seed = 22159;
    hard_rst;
    chk({31'h0, rate}, 33'h2);
    wr(`FRS_IDX_MODE, 8'h02);
    rd(`FRS_IDX_DIR_CCR, 8'h82);
    wr(`FRS_IDX_DIR_CCR, 8'hFF);
    rd(`FRS_IDX_DIR_CCR, 8'h87);
    wr(`FRS_IDX_DOR, 8'h08);
    wr(`FRS_IDX_CTRL, 8'h01);
    #1 chk({32'h0, crst}, 33'h1);
    rd(`FRS_IDX_DIR_CCR, 8'h8F);
    chk({31'h0, dma, noprec}, 33'h3);
    wr(`FRS_IDX_MODE, 8'h01);
    for (k = 0; k < 8; k++)
    begin
      v = $random(seed);
      wr(`FRS_IDX_DIR_CCR, v[7:0]);
      rd(`FRS_IDX_DIR_CCR, mb(1'b1, v[1:0]));
    end
    chk({32'h0, noprec}, 33'h1);
    dchg <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`FRS_IDX_DIR_CCR, mb(1'b0, v[1:0]));
    wr(`FRS_IDX_CTRL, 8'h02);
    rd(`FRS_IDX_DIR_CCR, mb(1'b1, v[1:0]));
    wr(`FRS_IDX_CTRL, 8'h00);
    dchg <= 1'b0;
    acc(1'b0, 8'h3C, 8'h00, {2'b11, 32'h0});
    acc(1'b0, 8'h1E, 8'h00, {2'b11, 32'h0});
    acc(1'b1, {`FRS_IDX_DATA, 2'b00}, 8'hFF, {2'b01, 32'h0});
    hard_rst;
    rd(`FRS_IDX_DIR_CCR, 8'h80);
    wr(`FRS_IDX_MODE, 8'h01);
    rd(`FRS_IDX_DIR_CCR, mb(1'b1, 2'b10));
    wr(`FRS_IDX_MODE, 8'h02);
    rd(`FRS_IDX_DIR_CCR, 8'h82);
    for (k = 0; k < 4; k++)
    begin
      v = $random(seed);
      @(posedge clk);
      start <= 1'b1;
      head <= v[0];
      drv <= v[2:1];
      term <= k[1:0];
      @(posedge clk);
      start <= 1'b0;
      {ndm, snf, late, crc, pls, spz, pdone} <= v[9:3];
      @(posedge clk);
      {pdone, spz, pls, crc, late, snf, ndm} <= 7'h00;
      if (k == 0 || k == 2)
      begin
        recal <= 1'b1;
        track_zero_pin <= k[1];
        repeat (80)
        begin
          @(posedge clk);
          step <= 1'b1;
          @(posedge clk);
          step <= 1'b0;
        end
        @(posedge clk);
        recal <= 1'b0;
        track_zero_pin <= 1'b0;
      end
      if (k == 1)
      begin
        wact <= 1'b1;
        wp <= 1'b1;
        repeat (5) @(posedge clk);
        wact <= 1'b0;
        wp <= 1'b0;
      end
      if (k >= 2)
      begin
        srch <= 1'b1;
        repeat (2)
        begin
          repeat (3) @(posedge clk);
          ipin <= 1'b1;
          found <= k[0];
          repeat (3) @(posedge clk);
          ipin <= 1'b0;
          found <= 1'b0;
        end
        repeat (4) @(posedge clk);
        srch <= 1'b0;
      end
      @(posedge clk);
      cdone <= 1'b1;
      @(posedge clk);
      cdone <= 1'b0;
      @(posedge clk);
      chk({32'h0, rphase}, 33'h1);
      rd(`FRS_IDX_DATA, {k[1:0], v[3], v[4] | (k == 0), 1'b0, v[0], v[2:1]});
      rd(`FRS_IDX_DATA,
        {v[5], 1'b0, v[6], v[7], 1'b0, v[8], k == 1, v[9] | (k == 2)});
      @(posedge clk);
      chk({32'h0, rphase}, 33'h0);
    end
    repeat (2) @(posedge clk);
    stop_test;
  end
endmodule
